//--- rtl/lgp_pkg.sv
package lgp_pkg;

    // ------------------------------------------------------------------
    // Register map, word offsets on the Avalon bus (byte address / 4).
    // ------------------------------------------------------------------
    localparam logic [2:0] LGP_ADDR_A_LATCH = 3'h0;   // Port A output latch.
    localparam logic [2:0] LGP_ADDR_A_DIR = 3'h1;     // Port A direction.
    localparam logic [2:0] LGP_ADDR_B_LATCH = 3'h2;   // Port B output latch.
    localparam logic [2:0] LGP_ADDR_B_DIR = 3'h3;     // Port B direction.
    localparam logic [2:0] LGP_ADDR_LCD_CTRL = 3'h4;  // Pin input gate and segment select.
    localparam logic [2:0] LGP_ADDR_COM_SEL = 3'h5;   // Backplane select per port A pin.
    localparam logic [2:0] LGP_ADDR_STANDBY = 3'h6;   // Standby pin float and mode.
    localparam logic [2:0] LGP_ADDR_LATCH_VIEW = 3'h7; // Read-modify-write read window.

    // ------------------------------------------------------------------
    // Field positions and reset values.
    // ------------------------------------------------------------------
    localparam int LGP_A_WIDTH = 8;                   // Pins on port A.
    localparam int LGP_B_WIDTH = 2;                   // Pins on port B.
    localparam int LGP_CTRL_GATE_BIT = 0;             // Pin input gate bit.
    localparam int LGP_CTRL_SEG_LSB = 1;              // Segment select, two bits.
    localparam int LGP_STBY_FLOAT_BIT = 0;            // Standby pin float bit.
    localparam int LGP_STBY_MODE_BIT = 1;             // Stop or watch mode active.
    localparam int LGP_VIEW_PORT_BIT = 0; // Latch view window: 0 port A, 1 port B.
    localparam logic [7:0] LGP_RST_DIR = 8'h00;       // Direction after reset.
    localparam logic [7:0] LGP_RST_LATCH = 8'h00;     // Latch after reset.
    localparam logic [7:0] LGP_RST_CTRL = 8'h00;      // Control registers after reset.
    localparam logic [31:0] LGP_UNMAPPED = 32'h00000000; // Read of a reserved word.

endpackage : lgp_pkg

//--- rtl/lgp_sync2.sv
// Two-flop synchroniser for a vector of pin levels.
module lgp_sync2 #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Raw and synchronised levels.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Synchroniser stages.
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_ff; // First stage, read only by the second stage.
    logic [WIDTH-1:0] sync_ff; // Second stage, safe to use.
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // Next values are plain copies down the chain.
    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    // Registers reset to low so a floating pin reads 0 at start.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;

endmodule // lgp_sync2

//--- rtl/lgp_pin_mux.sv
// Per-pin mux between port logic, LCD drive and standby float.
module lgp_pin_mux #(
    parameter int WIDTH = 8
) (
    // Port state.
    input wire logic [WIDTH-1:0] latch_in,
    input wire logic [WIDTH-1:0] dir_in,
    // LCD sharing.
    input wire logic [WIDTH-1:0] lcd_sel_in,
    input wire logic [WIDTH-1:0] lcd_drive_in,
    // Standby float request.
    input wire logic float_in,
    // Pin drive result.
    output logic [WIDTH-1:0] pin_o_out,
    output logic [WIDTH-1:0] pin_oe_out
);

    // ------------------------------------------------------------------
    // Output selection.
    // ------------------------------------------------------------------
    // Float wins over everything, then LCD, then the port direction.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (float_in) begin
                pin_o_out[i] = 1'b0;
                pin_oe_out[i] = 1'b0;
            end else if (lcd_sel_in[i]) begin
                pin_o_out[i] = lcd_drive_in[i];
                pin_oe_out[i] = 1'b1;
            end else begin
                pin_o_out[i] = latch_in[i];
                pin_oe_out[i] = dir_in[i];
            end
        end
    end

endmodule // lgp_pin_mux

//--- rtl/lgp_top.sv
// Contract
// - Direction 1 drives pin from latch.
// - Direction 0 makes pin an input.
// - Output pins show the latch bit.
// - Data writes always update the latch.
// - Plain read of output bits returns latch.
// - Plain read of input bits returns pin; here only while the pin input gate bit is set, else 0.
// - Read-modify-write reads return latch always.
// - Reset clears all direction bits.
// - Standby float: pins high-Z, inputs low.
// - Standby without float keeps pins unchanged.
// - Backplane select hands port A pin to LCD.
// - Segment select hands port B pin to LCD.
// - Port A has eight pins, bits 0-7.
// - Port B has two pins, bits 0-1.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.

module lgp_top
    import lgp_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Avalon-MM slave.
    input wire logic [2:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // LCD controller drive levels.
    input wire logic [LGP_A_WIDTH-1:0] lcd_com_in,
    input wire logic [LGP_B_WIDTH-1:0] lcd_seg_in,
    // Port A pins.
    input wire logic [LGP_A_WIDTH-1:0] pa_pin_in,
    output logic [LGP_A_WIDTH-1:0] pa_pin_out,
    output logic [LGP_A_WIDTH-1:0] pa_pin_oe_out,
    // Port B pins.
    input wire logic [LGP_B_WIDTH-1:0] pb_pin_in,
    output logic [LGP_B_WIDTH-1:0] pb_pin_out,
    output logic [LGP_B_WIDTH-1:0] pb_pin_oe_out
);

    // ------------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------------
    logic [7:0] port_a_output_latch_ff;           // Port A latch.
    logic [7:0] port_a_direction_ff;              // Port A direction.
    logic [LGP_B_WIDTH-1:0] port_b_output_latch_ff; // Port B latch, two bits.
    logic [LGP_B_WIDTH-1:0] port_b_direction_ff;  // Port B direction, two bits.
    logic lcd_pin_input_gate_ff;                  // Pin input gate.
    logic [LGP_B_WIDTH-1:0] lcd_drive_line_select_ff; // Segment select.
    logic [7:0] com_select_ff;                    // Backplane select.
    logic standby_pin_float_ff;                   // Float pins in standby.
    logic standby_mode_ff;                        // Stop or watch mode active.
    logic view_port_ff; // Latch view window port choice.
    logic [31:0] readdata_ff;                     // Registered read data.
    logic ack_ff;                                 // Answer cycle flag.
    logic [LGP_A_WIDTH-1:0] pa_o_ff, pa_oe_ff;    // Registered pin drive.
    logic [LGP_B_WIDTH-1:0] pb_o_ff, pb_oe_ff;

    logic [7:0] nxt_a_latch, nxt_a_dir, nxt_com_sel;
    logic [LGP_B_WIDTH-1:0] nxt_b_latch, nxt_b_dir, nxt_seg_sel;
    logic nxt_gate, nxt_float, nxt_mode, nxt_view_port, nxt_ack;
    logic [31:0] nxt_readdata;

    // Synchronised pin levels and pin mux results.
    logic [LGP_A_WIDTH-1:0] pa_sync, pa_mux_o, pa_mux_oe;
    logic [LGP_B_WIDTH-1:0] pb_sync, pb_mux_o, pb_mux_oe;
    logic [LGP_A_WIDTH-1:0] pa_level;
    logic [LGP_B_WIDTH-1:0] pb_level;
    logic pin_float;

    // ------------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------------
    // Byte-lane merge of the low byte of a write.
    function automatic logic [7:0] lane0(input logic [7:0] old_v, input logic [31:0] wd, input logic [3:0] be);
        lane0 = be[0] ? wd[7:0] : old_v;
    endfunction

    // Mixed read: latch for output bits, pin for input bits.
    function automatic logic [7:0] mix_read(input logic [7:0] latch, input logic [7:0] dir, input logic [7:0] pin);
        mix_read = (latch & dir) | (pin & ~dir);
    endfunction

    // ------------------------------------------------------------------
    // Pin input path.
    // ------------------------------------------------------------------
    lgp_sync2 #(.WIDTH(LGP_A_WIDTH)) u_sync_a (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(pa_pin_in),
        .sync_out(pa_sync)
    );

    lgp_sync2 #(.WIDTH(LGP_B_WIDTH)) u_sync_b (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(pb_pin_in),
        .sync_out(pb_sync)
    );

    // Float locks the internal input low; the gate bit must be set for
    // the input buffer to pass, so a cleared gate also reads low.
    assign pin_float = standby_mode_ff & standby_pin_float_ff;
    assign pa_level = (pin_float | ~lcd_pin_input_gate_ff) ? '0 : pa_sync;
    assign pb_level = (pin_float | ~lcd_pin_input_gate_ff) ? '0 : pb_sync;

    // ------------------------------------------------------------------
    // Pin output muxes.
    // ------------------------------------------------------------------
    lgp_pin_mux #(.WIDTH(LGP_A_WIDTH)) u_mux_a (
        .latch_in(port_a_output_latch_ff),
        .dir_in(port_a_direction_ff),
        .lcd_sel_in(com_select_ff),
        .lcd_drive_in(lcd_com_in),
        .float_in(pin_float),
        .pin_o_out(pa_mux_o),
        .pin_oe_out(pa_mux_oe)
    );

    lgp_pin_mux #(.WIDTH(LGP_B_WIDTH)) u_mux_b (
        .latch_in(port_b_output_latch_ff),
        .dir_in(port_b_direction_ff),
        .lcd_sel_in(lcd_drive_line_select_ff),
        .lcd_drive_in(lcd_seg_in),
        .float_in(pin_float),
        .pin_o_out(pb_mux_o),
        .pin_oe_out(pb_mux_oe)
    );

    // ------------------------------------------------------------------
    // Bus decode and next register values.
    // ------------------------------------------------------------------
    // Each request is answered one cycle after it arrives: waitrequest
    // is high in the first cycle and drops in the second. This keeps
    // read data registered at the cost of one extra cycle per access.
    always_comb begin
        nxt_a_latch = port_a_output_latch_ff;
        nxt_a_dir = port_a_direction_ff;
        nxt_b_latch = port_b_output_latch_ff;
        nxt_b_dir = port_b_direction_ff;
        nxt_gate = lcd_pin_input_gate_ff;
        nxt_seg_sel = lcd_drive_line_select_ff;
        nxt_com_sel = com_select_ff;
        nxt_float = standby_pin_float_ff;
        nxt_mode = standby_mode_ff;
        nxt_view_port = view_port_ff;
        nxt_readdata = readdata_ff;
        nxt_ack = 1'b0;
        if ((avs_read_in | avs_write_in) & ~ack_ff) begin
            nxt_ack = 1'b1;
            if (avs_write_in) begin
                case (avs_address_in)
                    LGP_ADDR_A_LATCH: nxt_a_latch = lane0(port_a_output_latch_ff, avs_writedata_in,
                                                          avs_byteenable_in);
                    LGP_ADDR_A_DIR: nxt_a_dir = lane0(port_a_direction_ff, avs_writedata_in, avs_byteenable_in);
                    LGP_ADDR_B_LATCH: begin
                        if (avs_byteenable_in[0]) begin
                            nxt_b_latch = avs_writedata_in[LGP_B_WIDTH-1:0];
                        end
                    end
                    LGP_ADDR_B_DIR: begin
                        if (avs_byteenable_in[0]) begin
                            nxt_b_dir = avs_writedata_in[LGP_B_WIDTH-1:0];
                        end
                    end
                    LGP_ADDR_LCD_CTRL: begin
                        if (avs_byteenable_in[0]) begin
                            nxt_gate = avs_writedata_in[LGP_CTRL_GATE_BIT];
                            nxt_seg_sel = avs_writedata_in[LGP_CTRL_SEG_LSB +: LGP_B_WIDTH];
                        end
                    end
                    LGP_ADDR_COM_SEL: nxt_com_sel = lane0(com_select_ff, avs_writedata_in,
                                                          avs_byteenable_in);
                    LGP_ADDR_STANDBY: begin
                        if (avs_byteenable_in[0]) begin
                            nxt_float = avs_writedata_in[LGP_STBY_FLOAT_BIT];
                            nxt_mode = avs_writedata_in[LGP_STBY_MODE_BIT];
                        end
                    end
                    LGP_ADDR_LATCH_VIEW: begin
                        if (avs_byteenable_in[0]) begin
                            nxt_view_port = avs_writedata_in[LGP_VIEW_PORT_BIT];
                        end
                    end
                    default: ;
                endcase
            end else begin
                case (avs_address_in)
                    LGP_ADDR_A_LATCH: nxt_readdata = {24'h000000,
                        mix_read(port_a_output_latch_ff, port_a_direction_ff, pa_level)};
                    LGP_ADDR_A_DIR: nxt_readdata = {24'h000000, port_a_direction_ff};
                    LGP_ADDR_B_LATCH: nxt_readdata = {24'h000000, mix_read({6'h00, port_b_output_latch_ff},
                        {6'h00, port_b_direction_ff}, {6'h00, pb_level})};
                    LGP_ADDR_B_DIR: nxt_readdata = {30'h00000000, port_b_direction_ff};
                    LGP_ADDR_LCD_CTRL: nxt_readdata = {29'h00000000, lcd_drive_line_select_ff,
                                                       lcd_pin_input_gate_ff};
                    LGP_ADDR_COM_SEL: nxt_readdata = {24'h000000, com_select_ff};
                    LGP_ADDR_STANDBY: nxt_readdata = {30'h00000000, standby_mode_ff, standby_pin_float_ff};
                    // Read-modify-write reads see the latch, never the pins.
                    LGP_ADDR_LATCH_VIEW: nxt_readdata = view_port_ff ? {30'h00000000, port_b_output_latch_ff}
                                                               : {24'h000000, port_a_output_latch_ff};
                    default: nxt_readdata = LGP_UNMAPPED;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Register update.
    // ------------------------------------------------------------------
    // Pin drive is registered too, so pins follow a write by one cycle.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_a_output_latch_ff <= LGP_RST_LATCH;
            port_a_direction_ff <= LGP_RST_DIR;
            port_b_output_latch_ff <= LGP_RST_LATCH[LGP_B_WIDTH-1:0];
            port_b_direction_ff <= LGP_RST_DIR[LGP_B_WIDTH-1:0];
            lcd_pin_input_gate_ff <= LGP_RST_CTRL[0];
            lcd_drive_line_select_ff <= LGP_RST_CTRL[LGP_B_WIDTH-1:0];
            com_select_ff <= LGP_RST_CTRL;
            standby_pin_float_ff <= LGP_RST_CTRL[0];
            standby_mode_ff <= LGP_RST_CTRL[0];
            view_port_ff <= LGP_RST_CTRL[0];
            readdata_ff <= LGP_UNMAPPED;
            ack_ff <= 1'b0;
            pa_o_ff <= '0;
            pa_oe_ff <= '0;
            pb_o_ff <= '0;
            pb_oe_ff <= '0;
        end else begin
            port_a_output_latch_ff <= nxt_a_latch;
            port_a_direction_ff <= nxt_a_dir;
            port_b_output_latch_ff <= nxt_b_latch;
            port_b_direction_ff <= nxt_b_dir;
            lcd_pin_input_gate_ff <= nxt_gate;
            lcd_drive_line_select_ff <= nxt_seg_sel;
            com_select_ff <= nxt_com_sel;
            standby_pin_float_ff <= nxt_float;
            standby_mode_ff <= nxt_mode;
            view_port_ff <= nxt_view_port;
            readdata_ff <= nxt_readdata;
            ack_ff <= nxt_ack;
            pa_o_ff <= pa_mux_o;
            pa_oe_ff <= pa_mux_oe;
            pb_o_ff <= pb_mux_o;
            pb_oe_ff <= pb_mux_oe;
        end
    end

    assign avs_readdata_out = readdata_ff;
    assign avs_waitrequest_out = ~ack_ff;
    assign pa_pin_out = pa_o_ff;
    assign pa_pin_oe_out = pa_oe_ff;
    assign pb_pin_out = pb_o_ff;
    assign pb_pin_oe_out = pb_oe_ff;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_DIR_DRIVE: assert property ((!pin_float && !com_select_ff[0])
        |=> pa_pin_oe_out[0] == $past(port_a_direction_ff[0]))
        else $error("Port A pin 0 enable does not follow direction.");
    AST_INPUT_NODRIVE: assert property ((!port_b_direction_ff[0] && !lcd_drive_line_select_ff[0])
        |=> !pb_pin_oe_out[0])
        else $error("Input pin of port B is driven.");
    AST_LATCH_ON_PIN: assert property ((port_a_direction_ff[3] && !pin_float && !com_select_ff[3])
        |=> pa_pin_out[3] == $past(port_a_output_latch_ff[3]))
        else $error("Output pin does not show latch.");
    AST_WRITE_LATCH: assert property ((avs_write_in && !ack_ff && avs_address_in == LGP_ADDR_A_LATCH
        && avs_byteenable_in[0]) |=> port_a_output_latch_ff == $past(avs_writedata_in[7:0]))
        else $error("Latch write lost.");
    AST_LATCH_VIEW: assert property ((avs_read_in && !ack_ff && avs_address_in == LGP_ADDR_LATCH_VIEW
        && !view_port_ff) |=> avs_readdata_out == {24'h000000, $past(port_a_output_latch_ff)})
        else $error("Latch view read did not return latch.");
    AST_FLOAT: assert property (pin_float
        |=> (pa_pin_oe_out == '0 && pb_pin_oe_out == '0))
        else $error("Pin driven during standby float.");
    AST_B_UPPER: assert property ((avs_read_in && !ack_ff && avs_address_in == LGP_ADDR_B_DIR)
        |=> avs_readdata_out[7:2] == 6'h00)
        else $error("Port B upper bits not zero.");
    AST_ANSWER: assert property (((avs_read_in || avs_write_in) && !ack_ff)
        |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("Bus answer not in one cycle.");
    AST_COM_SEL: assert property ((com_select_ff[7] && !pin_float)
        |=> pa_pin_oe_out[7] && pa_pin_out[7] == $past(lcd_com_in[7]))
        else $error("Backplane select not honoured.");

    COV_WRITE: cover property (avs_write_in && !avs_waitrequest_out);
    COV_READ: cover property (avs_read_in && !avs_waitrequest_out);
    COV_FLOAT: cover property (pin_float);
    COV_SEG: cover property (lcd_drive_line_select_ff != '0);

endmodule // lgp_top

//--- sim/lgp_pad_model.sv
// Board side of the pins: a pin that the block releases is driven by the board level.
module lgp_pad_model
    import lgp_pkg::*;
(
    // Block drive.
    input wire logic [LGP_A_WIDTH-1:0] pa_o_in,
    input wire logic [LGP_A_WIDTH-1:0] pa_oe_in,
    input wire logic [LGP_B_WIDTH-1:0] pb_o_in,
    input wire logic [LGP_B_WIDTH-1:0] pb_oe_in,
    // Levels that the board puts on released pins.
    input wire logic [LGP_A_WIDTH-1:0] board_a_in,
    input wire logic [LGP_B_WIDTH-1:0] board_b_in,
    // Resolved wire levels.
    output logic [LGP_A_WIDTH-1:0] pa_level_out,
    output logic [LGP_B_WIDTH-1:0] pb_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin shows the block's level, so a read of an output pin sees it too.
    assign pa_level_out = (pa_oe_in & pa_o_in) | (~pa_oe_in & board_a_in);
    assign pb_level_out = (pb_oe_in & pb_o_in) | (~pb_oe_in & board_b_in);
endmodule // lgp_pad_model

//--- sim/tb.sv
module tb import lgp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------------------------------
    // Signals.
    // -------------------------------------------------------------
    logic clk_in, rst_in, av_rd, av_wr, wreq;
    logic [2:0] av_addr;
    logic [31:0] av_wdata, rdata;
    logic [7:0] lcd_com, board_a, pa_lvl, pa_o, pa_oe;
    logic [1:0] lcd_seg, board_b, pb_lvl, pb_o, pb_oe;
    int err_count = 0;
    int cmp_count = 0;
    lgp_top dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(av_addr), .avs_read_in(av_rd),
        .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_byteenable_in(4'h1),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .lcd_com_in(lcd_com), .lcd_seg_in(lcd_seg),
        .pa_pin_in(pa_lvl), .pa_pin_out(pa_o), .pa_pin_oe_out(pa_oe),
        .pb_pin_in(pb_lvl), .pb_pin_out(pb_o), .pb_pin_oe_out(pb_oe));
    lgp_pad_model pads (.pa_o_in(pa_o), .pa_oe_in(pa_oe), .pb_o_in(pb_o), .pb_oe_in(pb_oe),
        .board_a_in(board_a), .board_b_in(board_b), .pa_level_out(pa_lvl), .pb_level_out(pb_lvl));
    // The clock runs at 25 MHz.
    initial begin
        clk_in = 1'h0;
        forever #20 clk_in = ~clk_in;
    end
    // -------------------------------------------------------------
    // Shared tasks.
    // -------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One Avalon access; the request stands until waitrequest is seen low at an edge.
    task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_in);
        av_addr <= a;
        av_rd <= ~w;
        av_wr <= w;
        av_wdata <= {24'h000000, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (wreq !== 1'h0 && n < 20);
        if (n >= 20) chk(32'h0000000F, 32'h00000000, "bus answer missing");
        q = rdata;
        av_rd <= 1'h0;
        av_wr <= 1'h0;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'h1, d, q);
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'h0, 8'h00, q);
        chk(q, exp, "register read");
    endtask
    // Pins settle after the sync chain and read register, 3 to 4 cycles.
    task automatic settle();
        repeat (6) @(posedge clk_in);
    endtask
    // -------------------------------------------------------------
    // Scenarios.
    // -------------------------------------------------------------
    task automatic t_reset();
        rd(LGP_ADDR_A_DIR, 32'h00000000);
        rd(LGP_ADDR_B_DIR, 32'h00000000);
        chk({24'h000000, pa_oe}, 32'h00000000, "port a enables");
        chk({30'h00000000, pb_oe}, 32'h00000000, "port b enables");
        $display("test reset done");
    endtask
    task automatic t_port_a();
        board_a <= 8'h3C;
        wr(LGP_ADDR_LCD_CTRL, 8'h01);
        wr(LGP_ADDR_A_LATCH, 8'hA5);
        wr(LGP_ADDR_A_DIR, 8'hFF);
        settle();
        chk({24'h000000, pa_oe}, 32'h000000FF, "a enables");
        chk({24'h000000, pa_o}, 32'h000000A5, "a drive");
        rd(LGP_ADDR_A_LATCH, 32'h000000A5);
        wr(LGP_ADDR_A_DIR, 8'h0F);
        wr(LGP_ADDR_A_LATCH, 8'h5A);
        settle();
        chk({24'h000000, pa_oe}, 32'h0000000F, "a mixed enables");
        chk({24'h000000, pa_o & 8'h0F}, 32'h0000000A, "a low drive");
        rd(LGP_ADDR_A_LATCH, 32'h0000003A);
        wr(LGP_ADDR_LATCH_VIEW, 8'h00);
        rd(LGP_ADDR_LATCH_VIEW, 32'h0000005A);
        $display("test port a done");
    endtask
    task automatic t_port_b();
        wr(LGP_ADDR_B_LATCH, 8'hFF);
        wr(LGP_ADDR_B_DIR, 8'hFF);
        settle();
        rd(LGP_ADDR_B_DIR, 32'h00000003);
        rd(LGP_ADDR_B_LATCH, 32'h00000003);
        chk({30'h00000000, pb_o & pb_oe}, 32'h00000003, "b drive");
        wr(LGP_ADDR_LATCH_VIEW, 8'h01);
        rd(LGP_ADDR_LATCH_VIEW, 32'h00000003);
        board_b <= 2'h1;
        wr(LGP_ADDR_B_DIR, 8'h00);
        settle();
        rd(LGP_ADDR_B_LATCH, 32'h00000001);
        $display("test port b done");
    endtask
    task automatic t_lcd();
        lcd_com <= 8'hC3;
        lcd_seg <= 2'h2;
        wr(LGP_ADDR_A_DIR, 8'h00);
        wr(LGP_ADDR_B_DIR, 8'h00);
        wr(LGP_ADDR_COM_SEL, 8'hF0);
        wr(LGP_ADDR_LCD_CTRL, 8'h05);
        settle();
        chk({24'h000000, pa_oe}, 32'h000000F0, "backplane enables");
        chk({24'h000000, pa_o & 8'hF0}, 32'h000000C0, "backplane drive");
        chk({30'h00000000, pb_oe}, 32'h00000002, "segment enables");
        chk({30'h00000000, pb_o & 2'h2}, 32'h00000002, "segment drive");
        rd(LGP_ADDR_COM_SEL, 32'h000000F0);
        rd(LGP_ADDR_LCD_CTRL, 32'h00000005);
        wr(LGP_ADDR_COM_SEL, 8'h00);
        wr(LGP_ADDR_LCD_CTRL, 8'h01);
        $display("test lcd done");
    endtask
    task automatic t_standby();
        wr(LGP_ADDR_A_LATCH, 8'hA5);
        wr(LGP_ADDR_A_DIR, 8'hFF);
        wr(LGP_ADDR_STANDBY, 8'h02);
        settle();
        chk({pa_oe, pa_o}, 32'h0000FFA5, "standby keeps drive");
        wr(LGP_ADDR_STANDBY, 8'h03);
        settle();
        chk({24'h000000, pa_oe}, 32'h00000000, "float enables");
        rd(LGP_ADDR_STANDBY, 32'h00000003);
        board_a <= 8'hFF;
        wr(LGP_ADDR_A_DIR, 8'h00);
        settle();
        rd(LGP_ADDR_A_LATCH, 32'h00000000);
        wr(LGP_ADDR_STANDBY, 8'h00);
        settle();
        rd(LGP_ADDR_A_LATCH, 32'h000000FF);
        $display("test standby done");
    endtask
    // -------------------------------------------------------------
    // Verdict, watchdog and main sequence.
    // -------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // About 36 accesses and 9 settles need far fewer than 5000 cycles.
    initial begin
        repeat (5000) @(posedge clk_in);
        err_count++;
        conclude();
    end
    initial begin
        rst_in = 1'h1;
        av_addr = 3'h0;
        av_rd = 1'h0;
        av_wr = 1'h0;
        av_wdata = 32'h00000000;
        lcd_com = 8'h00;
        lcd_seg = 2'h0;
        board_a = 8'h00;
        board_b = 2'h0;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'h0;
        t_reset();
        t_port_a();
        t_port_b();
        t_lcd();
        t_standby();
        conclude();
    end
endmodule // tb
